// [rtl/frcfg_map.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz device clock and 8-bit command-code register access
`ifndef FRCFG_MAP_SVH
`define FRCFG_MAP_SVH

// register offsets
`define FRCFG_SFR_ADDR     8'hBD
`define FRCFG_ONB_ADDR     8'hBE

// reset values
`define FRCFG_SFR_RST      8'h00
`define FRCFG_ONB_RST      8'h00

// serious fault response control bit positions
`define FRCFG_SFR_BUCK_LS  4
`define FRCFG_SFR_BOOST_LS 5
`define FRCFG_SFR_BUCK_HB  6
`define FRCFG_SFR_BOOST_HB 7

// on-time and balance field positions
`define FRCFG_ONB_MIN_LSB  0
`define FRCFG_ONB_WITHIN   2
`define FRCFG_ONB_BETWEEN  3

// clock rate and minimum on-time figures
`define FRCFG_CLK_MHZ      100
`define FRCFG_TON0_NS      340
`define FRCFG_TON1_NS      280
`define FRCFG_TON2_NS      220
`define FRCFG_TON3_NS      180

// least time in ns to clock cycles, rounded up
`define FRCFG_NS2CYC(ns)   ((((ns) * `FRCFG_CLK_MHZ) + 999) / 1000)

`endif

// [rtl/frcfg_pkg.sv]
// types shared by the fault response and on-time configuration block
// assumes frcfg_map.svh supplies all numeric constants
package frcfg_pkg;

  // latch-off state, gray along run -> latched -> rearm
  typedef enum logic [1:0] {
    FRCFG_RUN   = 2'h0,
    FRCFG_LATCH = 2'h1,
    FRCFG_REARM = 2'h3
  } frcfg_state_t;

  // detector reports and ordinary fault response requests
  typedef struct packed {
    logic ls_short;     // suspected low-side switch short
    logic hb_short;     // suspected high_voltage_bus short to ground
    logic noc_off;      // negative_overcurrent response wants switching off
    logic oc2_off;      // overcurrent_level2 response wants switching off
    logic uv_off;       // low_bus_undervoltage response wants switching off
  } frcfg_fault_t;

  // on-time and balance register layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic       bal_between;
    logic       bal_within;
    logic [1:0] min_on;
  } frcfg_onb_t;

endpackage

// [rtl/frcfg_minon.sv]
// minimum on-time pulse stretcher for the main switch
// assumes demand is a same-clock level and kill overrides the stretch
`timescale 1ns/1ps

module frcfg_minon (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  // control
  input  wire logic       demand_i,
  input  wire logic       kill_i,
  input  wire logic [5:0] min_cyc_i,
  // pulse
  output logic            on_o
);

  logic       on_r;
  logic       on_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  // start loads the least length minus one, the pulse ends when both count and demand are done
  always_comb begin
    on_nxt  = on_r;
    cnt_nxt = cnt_r;
    if (kill_i) begin
      on_nxt  = 1'h0;
      cnt_nxt = 6'h00;
    end else if (!on_r) begin
      if (demand_i) begin
        on_nxt  = 1'h1;
        cnt_nxt = min_cyc_i - 6'h01;
      end
    end else begin
      if (cnt_r != 6'h00) begin
        cnt_nxt = cnt_r - 6'h01;
      end
      // the load of the least length minus one counts down to zero, so the pulse lasts it in full
      on_nxt = (cnt_r != 6'h00) || demand_i;
    end
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_r  <= 1'h0;
      cnt_r <= 6'h00;
    end else if (ce_i) begin
      on_r  <= on_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign on_o = on_r;

endmodule

// [rtl/frcfg_top.sv]
// serious fault response, minimum on-time and current balance configuration
// assumes detector and modulator inputs share clk_i; enable pins are asynchronous
`timescale 1ns/1ps

`include "frcfg_map.svh"

// How it works
// - bit4 clear, buck low-side short: fail low, switching latched off.
// - bit4 set, buck low-side short: fail released, follow negative overcurrent, undervoltage.
// - bit5 picks boost low-side short: latch-off with fail, or defer.
// - bit6 picks buck high bus short: latch-off with fail, or defer.
// - bit7 picks boost high bus short: latch-off with fail, or defer.
// - latched off until chip enable or switching enable is toggled.
// - bits 1:0 pick least pulse 340, 280, 220 or 180 ns.
// - least pulse applies to high side in buck, low side in boost.
// - bit2 enables balance within device, bit3 between devices.
// - on-time register is one byte, writable, resets to zero.
// - a failing serious fault stops switching and drives fail low.
module frcfg_top
  import frcfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         ce_i,
  // register access by command code
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  output logic [7:0]        reg_rdata_o,
  output logic              reg_ack_o,
  // enable pins, asynchronous
  input  wire logic         chip_en_i,
  input  wire logic         sw_en_i,
  // power stage status, same clock
  input  wire logic         dir_boost_i,
  input  wire frcfg_fault_t fault_i,
  input  wire logic         pwm_demand_i,
  // outputs to power stage and shutdown circuit
  output logic              system_fail_n_o,
  output logic              pwm_allow_o,
  output logic              hs_gate_o,
  output logic              ls_gate_o,
  output logic              bal_within_o,
  output logic              bal_between_o,
  output logic [5:0]        min_on_cyc_o
);

  // minimum on-time counts
  localparam logic [5:0] TON0_CYC = 6'(`FRCFG_NS2CYC(`FRCFG_TON0_NS));
  localparam logic [5:0] TON1_CYC = 6'(`FRCFG_NS2CYC(`FRCFG_TON1_NS));
  localparam logic [5:0] TON2_CYC = 6'(`FRCFG_NS2CYC(`FRCFG_TON2_NS));
  localparam logic [5:0] TON3_CYC = 6'(`FRCFG_NS2CYC(`FRCFG_TON3_NS));

  // decode the on-time field to cycles
  function automatic logic [5:0] ton_cycles(input logic [1:0] sel);
    logic [5:0] c;
    c = TON0_CYC;
    unique case (sel)
      2'h0: c = TON0_CYC;
      2'h1: c = TON1_CYC;
      2'h2: c = TON2_CYC;
      2'h3: c = TON3_CYC;
    endcase
    return c;
  endfunction

  // does this short latch off, given its control bit
  function automatic logic trips(input logic det, input logic defer_bit);
    return det && !defer_bit;
  endfunction

  // register state
  logic [7:0]   sfr_r;
  logic [7:0]   sfr_nxt;
  frcfg_onb_t   onb_r;
  frcfg_onb_t   onb_nxt;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic         ack_r;
  logic         ack_nxt;

  // enable pin synchronisers
  logic [2:0]   cen_sync_r;
  logic [2:0]   sen_sync_r;
  logic         cen_f_r;
  logic         cen_f_nxt;
  logic         sen_f_r;
  logic         sen_f_nxt;

  // latch-off state and outputs
  frcfg_state_t state_r;
  frcfg_state_t state_nxt;
  logic         fail_n_r;
  logic         fail_n_nxt;
  logic         allow_r;
  logic         allow_nxt;
  logic         hs_r;
  logic         hs_nxt;
  logic         ls_r;
  logic         ls_nxt;
  logic         bw_r;
  logic         bb_r;
  logic [5:0]   mcyc_r;

  // fault decisions
  logic         buck_ls_trip;
  logic         boost_ls_trip;
  logic         buck_hb_trip;
  logic         boost_hb_trip;
  logic         trip;
  logic         defer_stop;
  logic         en_both;
  logic         en_dropped;
  logic         main_on;

  // register writes and read answer
  always_comb begin
    sfr_nxt   = sfr_r;
    onb_nxt   = onb_r;
    rdata_nxt = rdata_r;
    ack_nxt   = 1'h0;
    if (reg_wr_i) begin
      if (reg_addr_i == `FRCFG_SFR_ADDR) begin
        sfr_nxt = reg_wdata_i;
      end
      if (reg_addr_i == `FRCFG_ONB_ADDR) begin
        onb_nxt = frcfg_onb_t'(reg_wdata_i);
      end
    end
    if (reg_rd_i) begin
      ack_nxt = 1'h1;
      if (reg_addr_i == `FRCFG_SFR_ADDR) begin
        rdata_nxt = sfr_r;
      end else if (reg_addr_i == `FRCFG_ONB_ADDR) begin
        rdata_nxt = onb_r;
      end else begin
        rdata_nxt = 8'h00;  // unmapped reads zero
      end
    end
  end

  // register file
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sfr_r   <= `FRCFG_SFR_RST;
      onb_r   <= frcfg_onb_t'(`FRCFG_ONB_RST);
      rdata_r <= 8'h00;
      ack_r   <= 1'h0;
    end else if (ce_i) begin
      sfr_r   <= sfr_nxt;
      onb_r   <= onb_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // filtered enable levels change once stages two and three agree
  always_comb begin
    cen_f_nxt = cen_f_r;
    sen_f_nxt = sen_f_r;
    if (cen_sync_r[1] == cen_sync_r[2]) begin
      cen_f_nxt = cen_sync_r[2];
    end
    if (sen_sync_r[1] == sen_sync_r[2]) begin
      sen_f_nxt = sen_sync_r[2];
    end
  end

  // enable pin synchronisers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cen_sync_r <= 3'h0;
      sen_sync_r <= 3'h0;
      cen_f_r    <= 1'h0;
      sen_f_r    <= 1'h0;
    end else if (ce_i) begin
      cen_sync_r <= {cen_sync_r[1:0], chip_en_i};
      sen_sync_r <= {sen_sync_r[1:0], sw_en_i};
      cen_f_r    <= cen_f_nxt;
      sen_f_r    <= sen_f_nxt;
    end
  end

  assign en_both    = cen_f_r && sen_f_r;
  assign en_dropped = !cen_f_r || !sen_f_r;

  // per-fault latch-off decisions, steered by present direction
  // direction picks the bit
  assign buck_ls_trip  = !dir_boost_i && trips(fault_i.ls_short, sfr_r[`FRCFG_SFR_BUCK_LS]);
  assign boost_ls_trip = dir_boost_i && trips(fault_i.ls_short, sfr_r[`FRCFG_SFR_BOOST_LS]);
  assign buck_hb_trip  = !dir_boost_i && trips(fault_i.hb_short, sfr_r[`FRCFG_SFR_BUCK_HB]);
  assign boost_hb_trip = dir_boost_i && trips(fault_i.hb_short, sfr_r[`FRCFG_SFR_BOOST_HB]);
  assign trip          = buck_ls_trip || boost_ls_trip || buck_hb_trip || boost_hb_trip;

  // deferred shorts follow the ordinary responses
  always_comb begin
    defer_stop = 1'h0;
    if (fault_i.ls_short && !dir_boost_i) begin
      defer_stop = fault_i.noc_off || fault_i.uv_off;
    end
    if (fault_i.ls_short && dir_boost_i) begin
      defer_stop = defer_stop || fault_i.oc2_off || fault_i.uv_off;
    end
    if (fault_i.hb_short) begin
      defer_stop = defer_stop || fault_i.oc2_off || fault_i.uv_off;
    end
  end

  // latch-off sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FRCFG_RUN: begin
        if (trip) begin
          state_nxt = FRCFG_LATCH;
        end
      end
      FRCFG_LATCH: begin
        // wait for an enable to drop
        if (en_dropped) begin
          state_nxt = FRCFG_REARM;
        end
      end
      FRCFG_REARM: begin
        if (en_both) begin
          state_nxt = FRCFG_RUN;
        end
      end
      default: begin
        state_nxt = FRCFG_LATCH;
      end
    endcase
  end

  // outputs follow the next state so a trip shows one edge later
  always_comb begin
    fail_n_nxt = (state_nxt == FRCFG_RUN);
    allow_nxt  = (state_nxt == FRCFG_RUN) && en_both && !defer_stop;
    hs_nxt     = main_on && !dir_boost_i && allow_nxt;
    ls_nxt     = main_on && dir_boost_i && allow_nxt;
  end

  // minimum on-time stretcher for the main switch
  // least pulse from field
  frcfg_minon u_minon (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .demand_i  (pwm_demand_i),
    .kill_i    (!allow_nxt),
    .min_cyc_i (ton_cycles(onb_r.min_on)),
    .on_o      (main_on)
  );

  // state and output registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r  <= FRCFG_RUN;
      fail_n_r <= 1'h1;
      allow_r  <= 1'h0;
      hs_r     <= 1'h0;
      ls_r     <= 1'h0;
      bw_r     <= 1'h0;
      bb_r     <= 1'h0;
      mcyc_r   <= TON0_CYC;
    end else if (ce_i) begin
      state_r  <= state_nxt;
      fail_n_r <= fail_n_nxt;
      allow_r  <= allow_nxt;
      hs_r     <= hs_nxt;
      ls_r     <= ls_nxt;
      bw_r     <= onb_r.bal_within;
      bb_r     <= onb_r.bal_between;
      mcyc_r   <= ton_cycles(onb_r.min_on);
    end
  end

  assign reg_rdata_o     = rdata_r;
  assign reg_ack_o       = ack_r;
  assign system_fail_n_o = fail_n_r;
  assign pwm_allow_o     = allow_r;
  assign hs_gate_o       = hs_r;
  assign ls_gate_o       = ls_r;
  assign bal_within_o    = bw_r;
  assign bal_between_o   = bb_r;
  assign min_on_cyc_o    = mcyc_r;

  // helper: length of the current main pulse in enabled cycles
  logic [7:0] on_len_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      on_len_r <= 8'h00;
    end else if (ce_i) begin
      on_len_r <= main_on ? 8'(on_len_r + 8'h01) : 8'h00;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  chk_buck_ls_trip: assert property (
    ce_i && state_r == FRCFG_RUN && fault_i.ls_short && !dir_boost_i
      && !sfr_r[`FRCFG_SFR_BUCK_LS] |=> !system_fail_n_o && !pwm_allow_o)
    else $error("buck low-side short did not latch off");

  chk_buck_ls_defer: assert property (
    ce_i && state_r == FRCFG_RUN && fault_i.ls_short && !fault_i.hb_short
      && !dir_boost_i && sfr_r[`FRCFG_SFR_BUCK_LS] |=> system_fail_n_o)
    else $error("deferred buck low-side short pulled fail low");

  chk_boost_ls_trip: assert property (
    ce_i && state_r == FRCFG_RUN && fault_i.ls_short && dir_boost_i
      && !sfr_r[`FRCFG_SFR_BOOST_LS] |=> !system_fail_n_o)
    else $error("boost low-side short did not latch off");

  chk_buck_hb_trip: assert property (
    ce_i && state_r == FRCFG_RUN && fault_i.hb_short && !dir_boost_i
      && !sfr_r[`FRCFG_SFR_BUCK_HB] |=> !system_fail_n_o)
    else $error("buck bus short did not latch off");

  chk_boost_hb_trip: assert property (
    ce_i && state_r == FRCFG_RUN && fault_i.hb_short && dir_boost_i
      && !sfr_r[`FRCFG_SFR_BOOST_HB] |=> !system_fail_n_o)
    else $error("boost bus short did not latch off");

  chk_latch_hold: assert property (
    state_r == FRCFG_LATCH && ce_i && en_both |=> state_r == FRCFG_LATCH [*1]
      ##0 !system_fail_n_o)
    else $error("latch released without an enable toggle");

  chk_minon_len: assert property (
    ce_i && main_on && !u_minon.on_nxt && allow_nxt
      |-> on_len_r + 8'h01 >= {2'h0, ton_cycles(onb_r.min_on)})
    else $error("main pulse shorter than minimum on-time");

  chk_gate_route: assert property (
    hs_gate_o |-> !ls_gate_o && $past(!dir_boost_i))
    else $error("main pulse routed to wrong switch");

  chk_bal_out: assert property (
    ce_i ##1 ce_i |-> bal_within_o == $past(onb_r.bal_within)
      && bal_between_o == $past(onb_r.bal_between))
    else $error("balance enable outputs do not follow register");

  chk_onb_reset: assert property (
    $past(srst_i) |-> onb_r == frcfg_onb_t'(`FRCFG_ONB_RST))
    else $error("on-time register not zero after reset");

  chk_fail_stops: assert property (
    !system_fail_n_o |-> !hs_gate_o && !ls_gate_o && !pwm_allow_o)
    else $error("switching active while fail asserted");

endmodule

// [bench/frcfg_stage_model.sv]
// model of the power stage and external shutdown circuit
// assumes one clock shared with the device; the switching enable pin is driven here on request
`timescale 1ns/1ps

module frcfg_stage_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // from the device
  input  wire logic       system_fail_n_i,
  input  wire logic       hs_gate_i,
  input  wire logic       ls_gate_i,
  // from the bench
  input  wire logic       rearm_i,
  // observations and switching enable pin
  output logic            sw_en_o,
  output logic            shut_seen_o,
  output logic            pulse_ls_o,
  output logic [7:0]      pulse_len_o
);
  logic [7:0] cnt_r;
  logic [7:0] off_r;

  // enable toggle: switching enable held low for eight cycles on request
  assign sw_en_o = (off_r == 8'h00);

  // shutdown latch, rearm counter and gate pulse length meter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shut_seen_o <= 1'b0;
      off_r       <= 8'h00;
      cnt_r       <= 8'h00;
      pulse_len_o <= 8'h00;
      pulse_ls_o  <= 1'b0;
    end else begin
      if (!system_fail_n_i) shut_seen_o <= 1'b1; // system turned off
      else if (rearm_i) shut_seen_o <= 1'b0;
      if (rearm_i) off_r <= 8'h08;
      else if (off_r != 8'h00) off_r <= off_r - 8'h01;
      if (hs_gate_i | ls_gate_i) begin
        cnt_r      <= cnt_r + 8'h01;
        pulse_ls_o <= ls_gate_i;
      end else if (cnt_r != 8'h00) begin
        pulse_len_o <= cnt_r;
        cnt_r       <= 8'h00;
      end
    end
  end
endmodule

// [bench/tb_frcfg_top.sv]
// self-checking bench for the fault response and on-time configuration block
// assumes the stage model answers on the far side and drives the switching enable
`timescale 1ns/1ps

`include "frcfg_map.svh"

module tb_frcfg_top
  import frcfg_pkg::*;
;
  logic         clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         ce_i = 1'b1;
  logic         reg_wr_i = 1'b0;
  logic         reg_rd_i = 1'b0;
  logic [7:0]   reg_addr_i = 8'h00;
  logic [7:0]   reg_wdata_i = 8'h00;
  logic         chip_en_i = 1'b1;
  logic         dir_boost_i = 1'b0;
  frcfg_fault_t fault_i = '0;
  logic         pwm_demand_i = 1'b0;
  logic         rearm_i = 1'b0;
  logic [7:0]   reg_rdata_o;
  logic         reg_ack_o, system_fail_n_o, pwm_allow_o, hs_gate_o, ls_gate_o;
  logic         bal_within_o, bal_between_o, sw_en, shut_seen, pulse_ls;
  logic [5:0]   min_on_cyc_o;
  logic [7:0]   pulse_len;
  int           fail_count = 0;
  int           total_checks = 0;
  int           ns_tab[4] = '{340, 280, 220, 180};

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  frcfg_top u_frcfg_top (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .chip_en_i(chip_en_i), .sw_en_i(sw_en),
    .dir_boost_i(dir_boost_i), .fault_i(fault_i), .pwm_demand_i(pwm_demand_i),
    .system_fail_n_o(system_fail_n_o), .pwm_allow_o(pwm_allow_o), .hs_gate_o(hs_gate_o),
    .ls_gate_o(ls_gate_o), .bal_within_o(bal_within_o), .bal_between_o(bal_between_o),
    .min_on_cyc_o(min_on_cyc_o));

  frcfg_stage_model u_frcfg_stage_model (
    .clk_i(clk_i), .srst_i(srst_i), .system_fail_n_i(system_fail_n_o),
    .hs_gate_i(hs_gate_o), .ls_gate_i(ls_gate_o), .rearm_i(rearm_i), .sw_en_o(sw_en),
    .shut_seen_o(shut_seen), .pulse_ls_o(pulse_ls), .pulse_len_o(pulse_len));

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read answers on the same edge that takes the strobe, and stands one cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk_bit(reg_ack_o, 1'b1);
    chk_byte(reg_rdata_o, exp);
  endtask

  // wait for switching to be permitted again, bounded
  task automatic wait_run();
    for (int n = 0; n < 300 && pwm_allow_o !== 1'b1; n++) @(posedge clk_i);
    #1;
    chk_bit(pwm_allow_o, 1'b1);
    chk_bit(system_fail_n_o, 1'b1);
  endtask

  // report a short of kind k (0 ls buck, 1 ls boost, 2 hb buck, 3 hb boost)
  task automatic hit(input int k, input logic req, input logic ef, input logic ea);
    @(posedge clk_i);
    dir_boost_i <= k[0];
    pwm_demand_i <= 1'b1;
    fault_i.ls_short <= !k[1];
    fault_i.hb_short <= k[1];
    fault_i.noc_off <= req && (k == 0);
    fault_i.uv_off <= req && (k == 1);
    fault_i.oc2_off <= req && (k > 1);
    repeat (2) @(posedge clk_i);
    #1;
    chk_bit(system_fail_n_o, ef);
    chk_bit(pwm_allow_o, ea);
    if (!ea) chk_byte({6'h00, hs_gate_o, ls_gate_o}, 8'h00);
    @(posedge clk_i);
    fault_i <= '0;
    pwm_demand_i <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #300us;
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk_byte({2'h0, min_on_cyc_o}, 8'h22); // default 340 ns
    rd(`FRCFG_ONB_ADDR, 8'h00);
    rd(`FRCFG_SFR_ADDR, 8'h00);
    rd(8'hBF, 8'h00);
    wr(`FRCFG_ONB_ADDR, 8'hFF);
    rd(`FRCFG_ONB_ADDR, 8'hFF); // reserved bits writable
    wr(8'hBF, 8'hA5);
    rd(`FRCFG_SFR_ADDR, 8'h00);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(`FRCFG_ONB_ADDR, 8'h00);
    ce_i <= 1'b1;
    rd(`FRCFG_ONB_ADDR, 8'hFF);
    wait_run();
    // each on-time code, balance pair and conversion direction
    for (int i = 0; i < 4; i++) begin
      wr(`FRCFG_ONB_ADDR, 8'(i * 5));
      rd(`FRCFG_ONB_ADDR, 8'(i * 5));
      chk_byte({2'h0, min_on_cyc_o}, 8'(ns_tab[i] / 10));
      chk_bit(bal_within_o, i[0]);
      chk_bit(bal_between_o, i[1]);
      @(posedge clk_i);
      dir_boost_i <= i[0];
      pwm_demand_i <= 1'b1;
      @(posedge clk_i);
      pwm_demand_i <= 1'b0;
      repeat (60) @(posedge clk_i);
      chk_byte(pulse_len, 8'(ns_tab[i] / 10));
      chk_bit(pulse_ls, i[0]);
    end
    // each short kind: governing bit clear trips, set defers
    for (int k = 0; k < 4; k++) begin
      wr(`FRCFG_SFR_ADDR, ~(8'h01 << (4 + k)));
      rd(`FRCFG_SFR_ADDR, ~(8'h01 << (4 + k)));
      hit(k, 1'b0, 1'b0, 1'b0);
      chk_bit(shut_seen, 1'b1);
      @(posedge clk_i);
      if (k == 3) begin
        chip_en_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chip_en_i <= 1'b1;
      end else begin
        rearm_i <= 1'b1;
        @(posedge clk_i);
        rearm_i <= 1'b0;
      end
      wait_run();
      wr(`FRCFG_SFR_ADDR, 8'h01 << (4 + k));
      hit(k, 1'b0, 1'b1, 1'b1);
      hit(k, 1'b1, 1'b1, 1'b0);
      wait_run();
    end
    report_and_stop();
  end
endmodule
